// ===== ctm_top.sv
// compact 10-bit timer with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "ctm_regs.svh"
// How it works
// - writing compare-A low byte only loads the shared holding buffer
// - writing compare-A high byte stores high bits and copies buffer low
// - reading a high byte returns it and captures its low byte in buffer
// - reading a low byte returns the holding buffer, not the live byte
// - ten-bit up-counter advanced by the selected clock source
// - P compares period with counter bits 9..7, A compares all bits
// - no load; cleared by run rise, overflow or selected match
// - pause holds the counter, counting resumes from the held value
// - clock select picks sys/4, sys, high/16, high/64, sub, pin edges
// - run rise zeroes counter; run fall stops and keeps the value
// - run rise in compare or pwm mode resets pin to initial level
// - P period is value times 128 clocks, zero means 1024
// - clear source zero lets a P match clear the counter outside pwm mode
// - mode 00 compare, 10 pwm, 11 timer, 01 undefined
// - compare mode A match: keep, drive low, drive high or toggle
// - pwm output function: inactive, active, waveform, undefined
// - a requested level equal to the present one shows no change
// - output control sets initial level or pwm active level
// - invert bit inverts the output pin, not in timer mode
// - swap bit exchanges period and duty roles in pwm mode
// - outside pwm, clear source one lets an A match clear, no P flag raised
// - pwm duty at or above period gives full duty

module ctm_top #(
    parameter int CNT_W = 10,
    parameter int PER_W = 3,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          fh_tick,
    input  wire logic          fsub_tick,
    input  wire logic          external_clock_pin,
    output logic               timer_output_pin,
    output logic               comparator_a_flag,
    output logic               comparator_p_flag
);
    localparam int LOW_W = CNT_W - PER_W;

    // control registers, counter, flags, apb and pin state
    logic [7:0]       ctrl_a_q;
    logic [7:0]       ctrl_b_q;
    logic [CNT_W-1:0] cmpa_q;
    logic [7:0]       hold_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             run_prev_q;
    logic             level_q;
    logic             level_d;
    logic             flag_a_q;
    logic             flag_p_q;
    logic             rdy_q;
    logic [31:0]      rdata_q;
    logic             err_q;
    logic             pin_q;

    // control fields
    wire logic                  pause_control;
    wire ctm_pkg::ctm_clk_sel_t counter_clock_select;
    wire logic                  run_enable;
    wire logic [PER_W-1:0]      period_value;
    wire ctm_pkg::ctm_mode_t    mode_field;
    wire logic [1:0]            output_function_field;
    wire logic                  output_control_bit;
    wire logic                  output_invert_bit;
    wire logic                  period_duty_swap;
    wire logic                  clear_source_select;

    assign pause_control   = ctrl_a_q[`CTM_A_PAUSE];
    assign counter_clock_select =
        ctm_pkg::ctm_clk_sel_t'(ctrl_a_q[`CTM_A_CLK_HI:`CTM_A_CLK_LO]);
    assign run_enable      = ctrl_a_q[`CTM_A_RUN];
    assign period_value    = ctrl_a_q[`CTM_A_PER_HI:`CTM_A_PER_LO];
    assign mode_field      =
        ctm_pkg::ctm_mode_t'(ctrl_b_q[`CTM_B_MODE_HI:`CTM_B_MODE_LO]);
    assign output_function_field = ctrl_b_q[`CTM_B_OFN_HI:`CTM_B_OFN_LO];
    assign output_control_bit    = ctrl_b_q[`CTM_B_OCTL];
    assign output_invert_bit     = ctrl_b_q[`CTM_B_INV];
    assign period_duty_swap      = ctrl_b_q[`CTM_B_SWAP];
    assign clear_source_select   = ctrl_b_q[`CTM_B_CLRSRC];

    // mode decode
    wire logic is_cmp;
    wire logic is_pwm;
    wire logic is_tmr;
    assign is_cmp = (mode_field == ctm_pkg::CTM_MODE_CMP);
    assign is_pwm = (mode_field == ctm_pkg::CTM_MODE_PWM);
    assign is_tmr = (mode_field == ctm_pkg::CTM_MODE_TMR);

    // counter clock source
    logic tick;

    ctm_tick #(
        .DIV_W (6)
    ) u_tick (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .sel         (counter_clock_select),
        .fh_tick     (fh_tick),
        .fsub_tick   (fsub_tick),
        .ext_clk_pin (external_clock_pin),
        .tick_q      (tick)
    );

    // counting enable and run edge
    wire logic run_rise;
    wire logic step;
    assign run_rise = run_enable && !run_prev_q;
    // a stopped or paused timer keeps its residual count
    assign step = tick && run_enable && !pause_control;

    // comparators look at the value the counter is about to reach,
    // so a match clears instead of showing the compare value itself
    wire logic [CNT_W-1:0] cnt_inc;
    wire logic             ovf;
    wire logic             hit_p;
    wire logic             hit_a;
    assign cnt_inc = cnt_q + CNT_W'(1);
    assign ovf     = (cnt_q == {CNT_W{1'b1}});
    // zero period matches on overflow: 1024 clocks
    assign hit_p   = (period_value == '0) ? ovf :
                     (cnt_inc[CNT_W-1:LOW_W] == period_value &&
                      cnt_inc[LOW_W-1:0] == '0);
    // zero compare value never matches, counter runs to overflow
    assign hit_a   = (cmpa_q != '0) && (cnt_inc == cmpa_q);

    // which comparator clears, by mode
    wire logic clr_by_a;
    wire logic clr_now;
    assign clr_by_a = is_pwm ? period_duty_swap :
                               clear_source_select;
    assign clr_now  = clr_by_a ? hit_a : (hit_p || ovf);

    // flag events; no P flag while A owns the clear outside pwm
    wire logic ev_a;
    wire logic ev_p;
    assign ev_a = step && hit_a;
    assign ev_p = step && hit_p && (is_pwm || !clear_source_select);

    // counter next value
    always_comb begin
        cnt_d = cnt_q;
        if (run_rise) begin
            cnt_d = '0;
        end else if (step) begin
            cnt_d = clr_now ? '0 : cnt_inc;
        end
    end

    // pwm duty threshold: period value in 128-clock units, zero is 1024
    wire logic [CNT_W:0] duty_p;
    wire logic [CNT_W:0] duty;
    wire logic           pwm_on;
    assign duty_p = (period_value == '0) ? (CNT_W+1)'(1 << CNT_W) :
                    (CNT_W+1)'({period_value, {LOW_W{1'b0}}});
    assign duty   = period_duty_swap ? duty_p :
                    (CNT_W+1)'(cmpa_q);
    // counter clears before reaching a duty at or beyond the period
    assign pwm_on = ({1'b0, cnt_q} < duty);

    // output level before inversion
    always_comb begin
        level_d = level_q;
        if (run_rise && (is_cmp || is_pwm)) begin
            level_d = output_control_bit;
        end else if (is_cmp && ev_a) begin
            unique case (output_function_field)
                2'h0: level_d = level_q;
                2'h1: level_d = 1'b0;
                2'h2: level_d = 1'b1;
                2'h3: level_d = !level_q;
            endcase
        end else if (is_pwm) begin
            unique case (output_function_field)
                2'h0: level_d = !output_control_bit;
                2'h1: level_d = output_control_bit;
                2'h2: level_d = pwm_on ? output_control_bit
                                       : !output_control_bit;
                2'h3: level_d = level_q;
            endcase
        end
    end

    // apb decode
    wire logic       acc;
    wire logic       done;
    wire logic       wr;
    wire logic       rd;
    wire logic [7:0] ofs;
    wire logic       hit_ctrl_a;
    wire logic       hit_ctrl_b;
    wire logic       hit_cnt_lo;
    wire logic       hit_cnt_hi;
    wire logic       hit_cmpa_lo;
    wire logic       hit_cmpa_hi;
    wire logic       hit_flags;
    wire logic       mapped;
    assign acc  = psel && penable;
    // the access ends on the edge where our registered pready is seen
    assign done = acc && rdy_q;
    assign wr   = done && pwrite && pstrb[0];
    // read effects share the edge that loads prdata, so a high-byte read
    // and its low-byte capture see one and the same counter value
    assign rd   = acc && !rdy_q && !pwrite;
    assign ofs  = 8'(paddr);
    assign hit_ctrl_a  = (ofs == `CTM_OFS_CTRL_A);
    assign hit_ctrl_b  = (ofs == `CTM_OFS_CTRL_B);
    assign hit_cnt_lo  = (ofs == `CTM_OFS_CNT_LO);
    assign hit_cnt_hi  = (ofs == `CTM_OFS_CNT_HI);
    assign hit_cmpa_lo = (ofs == `CTM_OFS_CMPA_LO);
    assign hit_cmpa_hi = (ofs == `CTM_OFS_CMPA_HI);
    assign hit_flags   = (ofs == `CTM_OFS_FLAGS);
    assign mapped = hit_ctrl_a || hit_ctrl_b || hit_cnt_lo || hit_cnt_hi ||
                    hit_cmpa_lo || hit_cmpa_hi || hit_flags;

    // read mux; unmapped reads return zero with an error
    wire logic [31:0] rmux;
    assign rmux =
        hit_ctrl_a  ? {24'h0, ctrl_a_q} :
        hit_ctrl_b  ? {24'h0, ctrl_b_q} :
        hit_cnt_lo  ? {24'h0, hold_q} :
        hit_cnt_hi  ? {30'h0, cnt_q[CNT_W-1:8]} :
        hit_cmpa_lo ? {24'h0, hold_q} :
        hit_cmpa_hi ? {30'h0, cmpa_q[CNT_W-1:8]} :
        hit_flags   ? {30'h0, flag_p_q, flag_a_q} :
                      32'h0;

    // apb handshake: one wait state so read data comes from a flop
    // ce low stalls the handshake as well, pready never pulses while frozen
    always_ff @(posedge clk) begin
        if (rst) begin
            rdy_q   <= 1'b0;
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
        end else if (ce) begin
            rdy_q   <= acc && !rdy_q;
            rdata_q <= rd ? rmux : 32'h0;
            err_q   <= acc && !rdy_q && !mapped;
        end
    end

    // control registers: software writes; the counter is read-only
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_a_q <= `CTM_RST_CTRL;
            ctrl_b_q <= `CTM_RST_CTRL;
        end else if (ce && wr) begin
            if (hit_ctrl_a) begin
                ctrl_a_q <= pwdata[7:0];
            end
            if (hit_ctrl_b) begin
                ctrl_b_q <= pwdata[7:0];
            end
        end
    end

    // compare value and shared low-byte holding buffer
    // one buffer serves every pair: a high read between a low write and
    // its high write overwrites the pending byte, so finish pairs in order
    always_ff @(posedge clk) begin
        if (rst) begin
            cmpa_q <= `CTM_RST_CMPA;
            hold_q <= 8'h00;
        end else if (ce) begin
            if (wr && hit_cmpa_lo) begin
                hold_q <= pwdata[7:0];
            end else if (wr && hit_cmpa_hi) begin
                cmpa_q <= {pwdata[CNT_W-9:0], hold_q};
            end else if (rd && hit_cnt_hi) begin
                hold_q <= cnt_q[7:0];
            end else if (rd && hit_cmpa_hi) begin
                hold_q <= cmpa_q[7:0];
            end
        end
    end

    // counter, run edge detect and output level
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q      <= '0;
            run_prev_q <= 1'b0;
            level_q    <= 1'b0;
        end else if (ce) begin
            cnt_q      <= cnt_d;
            run_prev_q <= run_enable;
            level_q    <= level_d;
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    // software clears a flag by writing a one to its bit
    wire logic clr_fa;
    wire logic clr_fp;
    assign clr_fa = wr && hit_flags && pwdata[`CTM_F_A];
    assign clr_fp = wr && hit_flags && pwdata[`CTM_F_P];
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
        end else if (ce) begin
            flag_a_q <= ev_a || (flag_a_q && !clr_fa);
            flag_p_q <= ev_p || (flag_p_q && !clr_fp);
        end
    end

    // pin: timer mode leaves it undriven-low, invert only outside it
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_q <= 1'b0;
        end else if (ce) begin
            pin_q <= is_tmr ? 1'b0 :
                     (level_q ^ output_invert_bit);
        end
    end

    assign prdata            = rdata_q;
    assign pready            = rdy_q;
    assign pslverr           = err_q;
    assign timer_output_pin  = pin_q;
    assign comparator_a_flag = flag_a_q;
    assign comparator_p_flag = flag_p_q;
endmodule : ctm_top
`default_nettype wire

// ===== ctm_regs.svh
// register offsets, field positions and reset values of the compact timer
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH

// byte addresses on the apb bus (low address bits only)
`define CTM_OFS_CTRL_A      8'h00
`define CTM_OFS_CTRL_B      8'h04
`define CTM_OFS_CNT_LO      8'h08
`define CTM_OFS_CNT_HI      8'h0C
`define CTM_OFS_CMPA_LO     8'h10
`define CTM_OFS_CMPA_HI     8'h14
`define CTM_OFS_FLAGS       8'h18

// timer_control_a fields
`define CTM_A_PAUSE         7
`define CTM_A_CLK_HI        6
`define CTM_A_CLK_LO        4
`define CTM_A_RUN           3
`define CTM_A_PER_HI        2
`define CTM_A_PER_LO        0

// timer_control_b fields
`define CTM_B_MODE_HI       7
`define CTM_B_MODE_LO       6
`define CTM_B_OFN_HI        5
`define CTM_B_OFN_LO        4
`define CTM_B_OCTL          3
`define CTM_B_INV           2
`define CTM_B_SWAP          1
`define CTM_B_CLRSRC        0

// flag register fields
`define CTM_F_A             0
`define CTM_F_P             1

// reset values
`define CTM_RST_CTRL        8'h00
`define CTM_RST_CMPA        10'h000

// clock prescale ratios
`define CTM_DIV_SYS         4
`define CTM_DIV_H16         16
`define CTM_DIV_H64         64

`endif

// ===== ctm_pkg.sv
// types of the compact timer
package ctm_pkg;

    // operating mode field
    typedef enum logic [1:0] {
        CTM_MODE_CMP   = 2'h0,
        CTM_MODE_UNDEF = 2'h1,
        CTM_MODE_PWM   = 2'h2,
        CTM_MODE_TMR   = 2'h3
    } ctm_mode_t;

    // counter clock source field
    typedef enum logic [2:0] {
        CTM_CK_SYS4  = 3'h0,
        CTM_CK_SYS   = 3'h1,
        CTM_CK_H16   = 3'h2,
        CTM_CK_H64   = 3'h3,
        CTM_CK_SUBA  = 3'h4,
        CTM_CK_SUBB  = 3'h5,
        CTM_CK_EXTR  = 3'h6,
        CTM_CK_EXTF  = 3'h7
    } ctm_clk_sel_t;

endpackage : ctm_pkg

// ===== ctm_tick.sv
// counter clock source selection: prescalers and external pin edges
`timescale 1ns/1ps
`default_nettype none
`include "ctm_regs.svh"

module ctm_tick #(
    parameter int DIV_W = 6
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire ctm_pkg::ctm_clk_sel_t sel,
    input  wire logic                  fh_tick,
    input  wire logic                  fsub_tick,
    input  wire logic                  ext_clk_pin,
    output logic                       tick_q
);
    logic [1:0]       sys_div_q;
    logic [DIV_W-1:0] h_div_q;
    logic             ext_prev_q;
    logic             sys4_w;
    logic             h16_w;
    logic             h64_w;
    logic             ext_rise_w;
    logic             ext_fall_w;
    logic             tick_d;

    // divider wraps: the tick fires on the last count of each window
    assign sys4_w = (sys_div_q == 2'(`CTM_DIV_SYS - 1));
    assign h16_w  = fh_tick && (h_div_q[3:0] == 4'(`CTM_DIV_H16 - 1));
    assign h64_w  = fh_tick && (h_div_q == DIV_W'(`CTM_DIV_H64 - 1));
    // pin is synchronous to clk, so one stored sample is enough
    assign ext_rise_w = ext_clk_pin && !ext_prev_q;
    assign ext_fall_w = !ext_clk_pin && ext_prev_q;

    // source select
    always_comb begin
        unique case (sel)
            ctm_pkg::CTM_CK_SYS4: tick_d = sys4_w;
            ctm_pkg::CTM_CK_SYS:  tick_d = 1'b1;
            ctm_pkg::CTM_CK_H16:  tick_d = h16_w;
            ctm_pkg::CTM_CK_H64:  tick_d = h64_w;
            ctm_pkg::CTM_CK_SUBA: tick_d = fsub_tick;
            ctm_pkg::CTM_CK_SUBB: tick_d = fsub_tick;
            ctm_pkg::CTM_CK_EXTR: tick_d = ext_rise_w;
            ctm_pkg::CTM_CK_EXTF: tick_d = ext_fall_w;
        endcase
    end

    // prescalers run free so a source switch needs no restart
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_div_q  <= 2'h0;
            h_div_q    <= '0;
            ext_prev_q <= 1'b0;
            tick_q     <= 1'b0;
        end else if (ce) begin
            sys_div_q  <= sys_div_q + 2'h1;
            if (fh_tick) begin
                h_div_q <= h_div_q + DIV_W'(1);
            end
            ext_prev_q <= ext_clk_pin;
            tick_q     <= tick_d;
        end
    end
endmodule : ctm_tick
`default_nettype wire

// ===== ctm_top_sva.sv
// port-level assertion checker for the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "ctm_regs.svh"
module ctm_top_chk #(
    parameter int AW = 8
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          timer_output_pin,
    input wire logic          comparator_a_flag,
    input wire logic          comparator_p_flag
);
    logic [7:0] cb_q;
    logic       run_q;
    logic [1:0] age_q;
    // write decode as seen on the bus, taken edge only
    wire       wr_ok = psel & penable & pready & pwrite & pstrb[0];
    wire       wr_a  = wr_ok & (paddr == `CTM_OFS_CTRL_A);
    wire       wr_b  = wr_ok & (paddr == `CTM_OFS_CTRL_B);
    wire [1:0] mode  = cb_q[7:6];
    wire [1:0] ofn   = cb_q[5:4];
    wire       lvl   = cb_q[3] ^ cb_q[2];
    // shadow controls; age gives the registered pin time to settle
    always_ff @(posedge clk) begin
        if (rst) begin
            cb_q  <= 8'h00;
            run_q <= 1'b0;
            age_q <= 2'h0;
        end else begin
            if (wr_b) cb_q <= pwdata[7:0];
            if (wr_a) run_q <= pwdata[3];
            age_q <= (wr_a | wr_b) ? 2'h0 :
                     (age_q == 2'h3 ? 2'h3 : age_q + 2'h1);
        end
    end
    default clocking dck @(posedge clk); endclocking
    default disable iff (rst);
    property p_rdy_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("late pready");
    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
    property p_err_rdy;
        pslverr |-> pready;
    endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("lone pslverr");
    property p_rd_zero;
        !(pready && !pwrite) |-> prdata == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("stray prdata");
    property p_hi_bits;
        pready && !pwrite && (paddr == `CTM_OFS_CNT_HI ||
            paddr == `CTM_OFS_CMPA_HI) |-> prdata[31:2] == 30'h0;
    endproperty
    a_hi_bits: assert property (p_hi_bits) else $error("high byte wide");
    property p_tmr_pin;
        mode == 2'h3 && age_q == 2'h3 |-> !timer_output_pin;
    endproperty
    a_tmr_pin: assert property (p_tmr_pin) else $error("pin in timer");
    property p_pwm_force;
        mode == 2'h2 && !ofn[1] && run_q && age_q == 2'h3
            |-> timer_output_pin == (lvl ^ !ofn[0]);
    endproperty
    a_pwm_force: assert property (p_pwm_force) else $error("pwm force");
    property p_run_init;
        wr_a && pwdata[3] && !run_q && mode == 2'h0
            |-> ##[1:3] timer_output_pin == lvl;
    endproperty
    a_run_init: assert property (p_run_init) else $error("init level");
    property p_cmp_set;
        $rose(comparator_a_flag) && mode == 2'h0 && (ofn[1] ^ ofn[0])
            && run_q && age_q == 2'h3
            |-> ##[0:3] timer_output_pin == (ofn[1] ^ cb_q[2]);
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("match level");
    property p_no_pflag;
        cb_q[0] && mode != 2'h2 && run_q && age_q == 2'h3
            && !comparator_p_flag |=> !comparator_p_flag;
    endproperty
    a_no_pflag: assert property (p_no_pflag) else $error("p flag set");
endmodule : ctm_top_chk
bind ctm_top ctm_top_chk #(.AW(AW)) i_ctm_top_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_output_pin(timer_output_pin),
    .comparator_a_flag(comparator_a_flag),
    .comparator_p_flag(comparator_p_flag));
`default_nettype wire

// ===== ctm_top_tb.sv
// self-checking bench for the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "ctm_regs.svh"
module ctm_top_tb;
    localparam logic W = 1'b1;
    localparam logic R = 1'b0;
    localparam int DIV [8] = '{4, 1, 32, 128, 8, 8, 16, 16};
    localparam logic [7:0] CB [13] = '{8'hA8, 8'hA8, 8'hAC, 8'hA0,
        8'hAA, 8'h98, 8'h88, 8'h31, 8'h21, 8'h19, 8'h09, 8'h29, 8'hF9};
    localparam logic [9:0] CA [13] = '{10'h0C8, 10'h020, 10'h020,
        10'h020, 10'h100, 10'h020, 10'h020, 10'h080, 10'h080, 10'h080,
        10'h080, 10'h080, 10'h080};
    localparam int HI [13] = '{1024, 256, 768, 768, 512, 1024, 0, 512,
        896, 128, 1024, 1024, 0};
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        fh_tick   = 1'b0;
    logic        fsub_tick = 1'b0;
    logic        ext_pin   = 1'b0;
    logic        ce        = 1'b1;
    logic [31:0] prdata;
    logic        pready, pslverr, pin, fa, fp, er;
    logic [31:0] rd;
    int          err_count = 0;
    int          checks    = 0;
    int          cyc       = 0;
    int          stamp;
    always #4 clk = ~clk;
    // tick sources: high clock every other cycle, sub every 8, pin period 16
    always @(posedge clk) begin
        cyc       <= cyc + 1;
        fh_tick   <= ~fh_tick;
        fsub_tick <= (cyc[2:0] == 3'h0);
        ext_pin   <= cyc[3];
    end
    ctm_top i_ctm_top (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fh_tick(fh_tick), .fsub_tick(fsub_tick),
        .external_clock_pin(ext_pin), .timer_output_pin(pin),
        .comparator_a_flag(fa), .comparator_p_flag(fp));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        // only the watchdog ends a stalled wait; one wait state is expected
        while (pready !== 1'b1) begin
            n++;
            @(posedge clk);
        end
        chk("pready wait", n, 32'h1);
        rd      = prdata;
        er      = pslverr;
        stamp   = cyc;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // high byte first so the low byte comes from the captured buffer
    task automatic rd10(output logic [9:0] v, output int t);
        apb(`CTM_OFS_CNT_HI, R, 32'h0);
        t       = stamp;
        v[9:8]  = rd[1:0];
        apb(`CTM_OFS_CNT_LO, R, 32'h0);
        v[7:0]  = rd[7:0];
    endtask : rd10
    // stop first: mode and output function change only while off
    task automatic start(input logic [7:0] cb, input logic [9:0] ca,
                         input logic [7:0] cta);
        apb(`CTM_OFS_CTRL_A, W, 32'h0);
        apb(`CTM_OFS_CTRL_B, W, {24'h0, cb});
        apb(`CTM_OFS_CMPA_LO, W, {24'h0, ca[7:0]});
        apb(`CTM_OFS_CMPA_HI, W, {30'h0, ca[9:8]});
        apb(`CTM_OFS_FLAGS, W, 32'h3);
        apb(`CTM_OFS_CTRL_A, W, {24'h0, cta});
    endtask : start
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial begin
        logic [9:0] v0, v1, dv, mx;
        int         t0, t1, d, hi_n;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // reset values, then the unmapped word at 0x1C
        for (int i = 0; i < 8; i++) begin
            apb(8'(i * 4), R, 32'h0);
            chk("reset read", rd, 32'h0);
            chk("pslverr", {31'h0, er}, {31'h0, i == 7});
        end
        // low write fills only the buffer, high write commits it
        apb(`CTM_OFS_CMPA_LO, W, 32'h5A);
        apb(`CTM_OFS_CMPA_HI, R, 32'h0);
        apb(`CTM_OFS_CMPA_LO, R, 32'h0);
        chk("cmpa low live", rd, 32'h0);
        apb(`CTM_OFS_CMPA_LO, W, 32'hA5);
        apb(`CTM_OFS_CMPA_HI, W, 32'h2);
        apb(`CTM_OFS_CMPA_LO, W, 32'h33);
        apb(`CTM_OFS_CMPA_HI, R, 32'h0);
        chk("cmpa high", rd, 32'h2);
        apb(`CTM_OFS_CMPA_LO, R, 32'h0);
        chk("cmpa low", rd, 32'hA5);
        apb(`CTM_OFS_CMPA_LO, W, 32'h33);
        apb(`CTM_OFS_CMPA_LO, R, 32'h0);
        chk("stale buffer", rd, 32'h33);
        // every clock source, counted over about 500 cycles
        for (int s = 0; s < 8; s++) begin
            start(8'hC0, 10'h000, 8'(s * 16 + 8));
            d = stamp;
            rd10(v0, t0);
            chk("zeroed", {31'h0, v0 <= (t0 - d) / DIV[s] + 1}, 32'h1);
            repeat (500) @(posedge clk);
            rd10(v1, t1);
            dv = v1 - v0;
            d  = (t1 - t0) / DIV[s];
            chk("rate", {31'h0, dv + 1 >= d && dv <= d + 1}, 32'h1);
        end
        // pause holds, resume continues, stop keeps, writes cannot load
        apb(`CTM_OFS_CTRL_A, W, 32'h98);
        rd10(v0, t0);
        repeat (100) @(posedge clk);
        rd10(v1, t1);
        chk("paused", {22'h0, v1}, {22'h0, v0});
        apb(`CTM_OFS_CTRL_A, W, 32'h18);
        t0 = stamp;
        // clock enable low for 50 cycles freezes the running count
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
        rd10(v1, t1);
        dv = v1 - v0;
        d  = t1 - t0 - 50;
        chk("resumed", {31'h0, dv <= d && dv + 3 >= d}, 32'h1);
        apb(`CTM_OFS_CTRL_A, W, 32'h10);
        rd10(v0, t0);
        apb(`CTM_OFS_CNT_LO, W, 32'hFF);
        apb(`CTM_OFS_CNT_HI, W, 32'h3);
        chk("cnt write err", {31'h0, er}, 32'h0);
        rd10(v1, t1);
        chk("stopped", {22'h0, v1}, {22'h0, v0});
        // A clear hides P flag; P clear at 128 counts raises both
        for (int k = 0; k < 2; k++) begin
            start(k ? 8'h00 : 8'h01, k ? 10'h032 : 10'h12C, 8'h19);
            mx = 10'h000;
            repeat (90) begin
                rd10(v0, t0);
                if (v0 > mx) mx = v0;
            end
            d = k ? 127 : 299;
            chk("max count", {31'h0, mx <= d && mx + 12 >= d}, 32'h1);
            apb(`CTM_OFS_FLAGS, R, 32'h0);
            chk("flags", rd, k ? 32'h3 : 32'h1);
        end
        // pin high time over 1024 clocks for pwm, compare and timer setups
        for (int r = 0; r < 13; r++) begin
            start(CB[r], CA[r], 8'h19);
            hi_n = 0;
            repeat (1024) begin
                @(posedge clk);
                hi_n += (pin === 1'b1);
            end
            chk("pin high", {31'h0, hi_n + 8 >= HI[r] && hi_n <= HI[r] + 8}, 32'h1);
        end
        close_out();
    end
endmodule : ctm_top_tb
`default_nettype wire
